// >>> tick_pkg.sv
// Purpose: Shared constants for the system tick down counter
// Assumes: Classic Wishbone slave, 32-bit data, byte addresses
// Notes:   Offsets are byte addresses of aligned words
package tick_pkg;
	localparam int          CNT_W           = 24;
	localparam logic [3:0]  OFS_CTRL_STATUS = 4'h0;
	localparam logic [3:0]  OFS_RELOAD      = 4'h4;
	localparam logic [3:0]  OFS_CURRENT     = 4'h8;
	localparam logic [3:0]  OFS_IRQ_STATUS  = 4'hc;
	localparam int          OFS_MSB         = 3;
	localparam int          BIT_ENABLE      = 0;
	localparam int          BIT_EXC_EN      = 1;
	localparam int          BIT_SOURCE      = 2;
	localparam int          BIT_FLAG        = 16;
	localparam int          BIT_IRQ_ZERO    = 0;
	localparam int          BIT_IRQ_MASK    = 8;
	localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;
	localparam logic [23:0] CNT_RESET       = 24'h00_0000;
	localparam logic [23:0] CNT_ONE         = 24'h00_0001;
	localparam int          SYNC_STAGES     = 3;
endpackage

// >>> system_tick_timer.sv
// Purpose: 24-bit wrap-on-zero down counter with reload and tick exception
// Assumes: Alternate tick clock arrives asynchronously; counted on its rising edge
// Notes:   Current value resets to zero; software should still clear it before enabling
// Function
// (R1) A 24-bit counter decrements once per selected tick and wraps through zero.
// (R2) When enabled and at zero, the next tick loads the reload value.
// (R3) The zero-reached flag in bit 16 sets on a count from 1 to 0.
// (R4) The flag is cleared by reading control/status or by any current-value write.
// (R5) A zero reload value keeps the counter at zero after reload.
// (R6) Software should clear the current value before enabling the counter.
// (R7) Source bit 2 high selects the core clock, low the alternate tick clock.
// (R8) Exception enable bit 1 makes a count to zero pend the tick exception.
// (R9) A software clear of the current value never pends the exception.
// (R10) Enable bit 0 stops the counter when low and runs it multi-shot when high.
// (R11) Reading the current value returns the counter at the sampling instant.
// (R12) Any write to the current-value register clears the counter to zero.
// (R13) Bits 31 to 24 of reload and current value read as zero.
// (R14) While disabled the counter holds and ticks affect neither flag nor exception.
//
// Added by the designer: register access over Wishbone.
`timescale 1ns/1ps
module system_tick_timer
	import tick_pkg::*;
(
	input  wire logic        CORE_CLK,
	input  wire logic        RSTN,
	input  wire logic        ALT_TICK_CLK,
	input  wire logic        WB_CYC_I,
	input  wire logic        WB_STB_I,
	input  wire logic        WB_WE_I,
	input  wire logic [3:0]  WB_ADR_I,
	input  wire logic [3:0]  WB_SEL_I,
	input  wire logic [31:0] WB_DAT_I,
	output logic      [31:0] WB_DAT_O,
	output logic             WB_ACK_O,
	output logic             TICK_PEND,
	output logic             IRQ
);

	// Three-stage synchroniser and tick selection
	logic [SYNC_STAGES-1:0] alt_sync_r;
	logic [SYNC_STAGES-1:0] alt_sync_nxt;
	logic                   alt_rise;
	logic                   core_tick;
	logic                   tick;
	logic                   step;

	// Counter state
	logic [CNT_W-1:0]       count_r;
	logic [CNT_W-1:0]       count_nxt;
	logic [CNT_W-1:0]       count_dec;
	logic                   count_is_zero;
	logic                   count_is_one;
	logic                   reload_now;
	logic                   dec_now;
	logic                   hit_zero;
	logic [CNT_W-1:0]       reload_r;

	// Control fields and their write data
	logic                   enable_r;
	logic                   exc_en_r;
	logic                   source_r;
	logic                   wdat_enable;
	logic                   wdat_exc_en;
	logic                   wdat_source;

	// Event state
	logic                   flag_r;
	logic                   flag_nxt;
	logic                   pend_r;
	logic                   pend_nxt;
	logic                   irq_stat_r;
	logic                   irq_stat_nxt;
	logic                   irq_mask_r;
	logic                   irq_level;

	// Bus decode
	logic                   req;
	logic                   wr;
	logic                   rd;
	logic [3:0]             ofs;
	logic                   sel_ctrl;
	logic                   sel_reload;
	logic                   sel_current;
	logic                   sel_irq;
	logic                   wr_ctrl;
	logic                   wr_reload;
	logic                   wr_reload_b0;
	logic                   wr_reload_b1;
	logic                   wr_reload_b2;
	logic                   wr_current;
	logic                   wr_irq;
	logic                   rd_ctrl;
	logic                   irq_clear;
	logic                   irq_mask_wr;

	// Read path
	logic                   ack_r;
	logic                   ack_nxt;
	logic [31:0]            dat_r;
	logic [31:0]            dat_nxt;
	logic [31:0]            rd_mux;
	logic [31:0]            ctrl_word;
	logic [31:0]            reload_word;
	logic [31:0]            current_word;
	logic [31:0]            irq_word;

	// A request is taken only while no acknowledge stands, so a held strobe is served every second cycle
	assign req          = WB_CYC_I & WB_STB_I & ~ack_r;
	assign wr           = req & WB_WE_I;
	assign rd           = req & ~WB_WE_I;
	assign ofs          = {WB_ADR_I[OFS_MSB:2], 2'b00};
	assign sel_ctrl     = (ofs == OFS_CTRL_STATUS);
	assign sel_reload   = (ofs == OFS_RELOAD);
	assign sel_current  = (ofs == OFS_CURRENT);
	assign sel_irq      = (ofs == OFS_IRQ_STATUS);
	assign wr_ctrl      = wr & sel_ctrl & WB_SEL_I[0];
	assign wr_reload    = wr & sel_reload;
	assign wr_reload_b0 = wr_reload & WB_SEL_I[0];
	assign wr_reload_b1 = wr_reload & WB_SEL_I[1];
	assign wr_reload_b2 = wr_reload & WB_SEL_I[2];
	// Byte enables are ignored: any write to the current value clears it
	assign wr_current   = wr & sel_current; // (R12)
	assign wr_irq       = wr & sel_irq;
	assign rd_ctrl      = rd & sel_ctrl; // (R4)
	assign irq_clear    = wr_irq & WB_SEL_I[0] & WB_DAT_I[BIT_IRQ_ZERO];
	assign irq_mask_wr  = wr_irq & WB_SEL_I[1];
	assign wdat_enable  = WB_DAT_I[BIT_ENABLE];
	assign wdat_exc_en  = WB_DAT_I[BIT_EXC_EN];
	assign wdat_source  = WB_DAT_I[BIT_SOURCE];

	// Only the second and third stages are compared; the first feeds the second alone
	assign alt_sync_nxt = {alt_sync_r[SYNC_STAGES-2:0], ALT_TICK_CLK};
	assign alt_rise     = alt_sync_r[SYNC_STAGES-2] & ~alt_sync_r[SYNC_STAGES-1];
	// The core clock path ticks every cycle; the alternate path once per pin rise
	assign core_tick    = 1'b1;
	assign tick         = source_r ? core_tick : alt_rise; // (R7)
	assign step         = enable_r & tick; // (R10) (R14)

	// Wrap detection works on the present count, before any clear
	assign count_is_zero = (count_r == CNT_RESET);
	assign count_is_one  = (count_r == CNT_ONE);
	assign count_dec     = count_r - CNT_ONE; // (R1)
	assign reload_now    = step & count_is_zero; // (R2)
	assign dec_now       = step & ~count_is_zero;
	assign hit_zero      = step & count_is_one; // (R3)

	// A clear from software outranks a tick in the same cycle
	always_comb begin
		count_nxt = count_r;
		if (wr_current) begin
			count_nxt = CNT_RESET; // (R12)
		end else if (reload_now) begin
			count_nxt = reload_r; // (R2) (R5)
		end else if (dec_now) begin
			count_nxt = count_dec; // (R1)
		end
	end

	// Hardware set beats the read clear; a current-value write cancels a same-cycle set
	always_comb begin
		flag_nxt = flag_r;
		if (rd_ctrl) begin
			flag_nxt = 1'b0; // (R4)
		end
		if (hit_zero) begin
			flag_nxt = 1'b1; // (R3)
		end
		if (wr_current) begin
			flag_nxt = 1'b0; // (R4)
		end
	end

	// A software clear never reaches the pend request
	assign pend_nxt = hit_zero & exc_en_r & ~wr_current; // (R8) (R9)

	// Status sets on every count to zero, whatever the exception enable; set wins
	always_comb begin
		irq_stat_nxt = irq_stat_r;
		if (irq_clear) begin
			irq_stat_nxt = 1'b0;
		end
		if (hit_zero) begin
			irq_stat_nxt = 1'b1;
		end
	end

	// Reserved control bits read as zero
	always_comb begin
		ctrl_word             = 32'h0000_0000;
		ctrl_word[BIT_ENABLE] = enable_r;
		ctrl_word[BIT_EXC_EN] = exc_en_r;
		ctrl_word[BIT_SOURCE] = source_r;
		ctrl_word[BIT_FLAG]   = flag_r;
	end

	// Interrupt word: sticky status and its mask
	always_comb begin
		irq_word               = 32'h0000_0000;
		irq_word[BIT_IRQ_ZERO] = irq_stat_r;
		irq_word[BIT_IRQ_MASK] = irq_mask_r;
	end

	// Upper byte is padded with zeros
	assign reload_word  = {{(32-CNT_W){1'b0}}, reload_r}; // (R13)
	assign current_word = {{(32-CNT_W){1'b0}}, count_r}; // (R11) (R13)

	// Every offset of the four-bit space is mapped
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (sel_ctrl) begin
			rd_mux = ctrl_word;
		end else if (sel_reload) begin
			rd_mux = reload_word;
		end else if (sel_current) begin
			rd_mux = current_word;
		end else if (sel_irq) begin
			rd_mux = irq_word;
		end
	end

	// Read data stands only in the acknowledge cycle and is zero otherwise
	assign dat_nxt = rd ? rd_mux : 32'h0000_0000;
	assign ack_nxt = req;

	// Reset clears every stage, so a pin already high at reset release gives one rise after reset
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			alt_sync_r <= '0;
		end else begin
			alt_sync_r <= alt_sync_nxt;
		end
	end

	// Current value is left at zero after reset, though software still clears it first
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			count_r <= CNT_RESET; // (R6)
		end else begin
			count_r <= count_nxt;
		end
	end

	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			flag_r <= 1'b0;
		end else begin
			flag_r <= flag_nxt;
		end
	end

	// Control bits follow byte lane zero only
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			enable_r <= CTRL_RESET[BIT_ENABLE];
		end else if (wr_ctrl) begin
			enable_r <= wdat_enable; // (R10)
		end
	end

	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			exc_en_r <= CTRL_RESET[BIT_EXC_EN];
		end else if (wr_ctrl) begin
			exc_en_r <= wdat_exc_en; // (R8)
		end
	end

	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			source_r <= CTRL_RESET[BIT_SOURCE];
		end else if (wr_ctrl) begin
			source_r <= wdat_source; // (R7)
		end
	end

	// Reload bytes follow the byte enables
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			reload_r <= CNT_RESET;
		end else begin
			if (wr_reload_b0) begin
				reload_r[7:0] <= WB_DAT_I[7:0];
			end
			if (wr_reload_b1) begin
				reload_r[15:8] <= WB_DAT_I[15:8];
			end
			if (wr_reload_b2) begin
				reload_r[23:16] <= WB_DAT_I[23:16];
			end
		end
	end

	// Pend is a single-cycle request; the exception side keeps its own pending state
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			pend_r <= 1'b0;
		end else begin
			pend_r <= pend_nxt;
		end
	end

	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			irq_stat_r <= 1'b0;
		end else begin
			irq_stat_r <= irq_stat_nxt;
		end
	end

	// Mask is written from byte lane one, so a status clear can leave it alone
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			irq_mask_r <= 1'b0;
		end else if (irq_mask_wr) begin
			irq_mask_r <= WB_DAT_I[BIT_IRQ_MASK];
		end
	end

	// Acknowledge is registered: one cycle of latency, dropped even if the strobe stays
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= ack_nxt;
		end
	end

	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			dat_r <= 32'h0000_0000;
		end else begin
			dat_r <= dat_nxt;
		end
	end

	assign irq_level = irq_stat_r & irq_mask_r;
	assign WB_ACK_O  = ack_r;
	assign WB_DAT_O  = dat_r;
	assign TICK_PEND = pend_r;
	assign IRQ       = irq_level;

endmodule // system_tick_timer

// >>> tick_checker_asserts.sv
// Purpose: Port checker for the tick timer
// Assumes: Enables mirrored from bus writes
// Notes: Waits two samples after an enable change
`timescale 1ns/1ps
module tick_checker
	import tick_pkg::*;
(
	input wire logic        CORE_CLK,
	input wire logic        RSTN,
	input wire logic        WB_CYC_I,
	input wire logic        WB_STB_I,
	input wire logic        WB_WE_I,
	input wire logic [3:0]  WB_ADR_I,
	input wire logic [3:0]  WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	input wire logic [31:0] WB_DAT_O,
	input wire logic        WB_ACK_O,
	input wire logic        TICK_PEND
);
	logic tk, en_r, exc_r;
	assign tk = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
	always_ff @(posedge CORE_CLK or negedge RSTN)
		if (!RSTN) {exc_r, en_r} <= 2'h0;
		else if (tk & WB_WE_I & WB_SEL_I[0] & (WB_ADR_I == OFS_CTRL_STATUS))
			{exc_r, en_r} <= WB_DAT_I[1:0];
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!RSTN);
	chk_ack_once: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack too long");
	chk_ack_latency: assert property (tk |=> WB_ACK_O) else $error("ack late");
	chk_ack_cause: assert property (WB_ACK_O |-> $past(tk)) else $error("stray ack");
	chk_rdata_idle: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0) else $error("data idle");
	chk_upper_zero: assert property (WB_ACK_O && $past(WB_ADR_I[3] ^ WB_ADR_I[2])
		|-> WB_DAT_O[31:24] == 8'h0) else $error("upper bits");
	chk_ctrl_rsv: assert property (WB_ACK_O && $past(!WB_WE_I && WB_ADR_I == OFS_CTRL_STATUS)
		|-> (WB_DAT_O & 32'hfffe_fff8) == 32'h0) else $error("ctrl layout");
	chk_pend_pulse: assert property (TICK_PEND |=> !TICK_PEND) else $error("pend");
	chk_cv_nopend: assert property (tk && WB_WE_I && WB_ADR_I == OFS_CURRENT
		|=> !TICK_PEND) else $error("pend on clear");
	chk_exc_off: assert property (!exc_r && !$past(exc_r) |-> !TICK_PEND) else $error("pend");
	chk_halt_pend: assert property (!en_r && !$past(en_r) |-> !TICK_PEND) else $error("pend");
	cover property (TICK_PEND);
	cover property (tk && WB_WE_I && WB_ADR_I == OFS_CURRENT);
	cover property (WB_ACK_O && $past(!WB_WE_I));
endmodule // tick_checker
bind system_tick_timer tick_checker tick_checker_i(.CORE_CLK(CORE_CLK), .RSTN(RSTN),
	.WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I),
	.WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
	.TICK_PEND(TICK_PEND));

// >>> tick_exc_model.sv
// Purpose: Exception controller model
// Assumes: Pend is a one-cycle pulse
// Notes: Counts pends, never refuses one
`timescale 1ns/1ps
module tick_exc_model (
	input  wire logic CORE_CLK,
	input  wire logic RSTN,
	input  wire logic TICK_PEND,
	output int        pend_cnt
);
	always_ff @(posedge CORE_CLK or negedge RSTN)
		if (!RSTN) pend_cnt <= 0;
		else if (TICK_PEND) pend_cnt <= pend_cnt + 1;
endmodule // tick_exc_model

// >>> system_tick_down_counter_tb.sv
// Purpose: Self-checking bench for the tick timer
// Assumes: Bus answers within 20 cycles
// Notes: Alternate ticks are slow, well above the sync depth
`timescale 1ns/1ps
module system_tick_down_counter_tb;
	import tick_pkg::*;
	logic clk = 0, rstn = 0, alt = 0, cyc = 0, we = 0, ack, pend, irq;
	logic [3:0] adr = 4'h0;
	logic [31:0] wd = 32'h0, rdt, q;
	int err_total = 0, checks_done = 0, pend_cnt, n, p;
	always #20 clk = ~clk;
	system_tick_timer system_tick_timer_i(.CORE_CLK(clk), .RSTN(rstn), .ALT_TICK_CLK(alt),
		.WB_CYC_I(cyc), .WB_STB_I(cyc), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf),
		.WB_DAT_I(wd), .WB_DAT_O(rdt), .WB_ACK_O(ack), .TICK_PEND(pend), .IRQ(irq));
	tick_exc_model tick_exc_model_i(.CORE_CLK(clk), .RSTN(rstn), .TICK_PEND(pend),
		.pend_cnt(pend_cnt));
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			err_total++;
			$display("mismatch at %0t: saw %h want %h", $time, s, e);
		end
	endtask
	task automatic complete_run;
		$display("errors %0d checks %0d", err_total, checks_done);
		if (err_total == 0 && checks_done > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// Request held until ack is sampled high at a rising edge; data taken at that edge
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		cyc <= 1'b1; we <= w; adr <= a; wd <= d;
		n = 0;
		do begin @(posedge clk); n++; end while (ack !== 1'b1 && n < 20);
		if (ack !== 1'b1) begin err_total++; complete_run; end
		q = rdt;
		cyc <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d); bus(1'b1, a, d); endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(q, e);
	endtask
	task automatic tick;
		alt <= 1'b1; repeat (6) @(posedge clk);
		alt <= 1'b0; repeat (6) @(posedge clk);
	endtask
	task automatic irq_is(input logic e);
		@(negedge clk) chk({31'h0, irq}, {31'h0, e});
		@(posedge clk);
	endtask
	task automatic s_alt;
		rd(OFS_CTRL_STATUS, CTRL_RESET);
		wr(OFS_RELOAD, 32'hff00_0003);
		rd(OFS_RELOAD, 32'h3);
		wr(OFS_CURRENT, 32'h5a);
		rd(OFS_CURRENT, 32'h0);
		wr(OFS_CTRL_STATUS, 32'h1);
		tick(); tick();
		wr(OFS_CTRL_STATUS, 32'h0);
		tick();
		rd(OFS_CURRENT, 32'h2);
	endtask
	task automatic s_core;
		wr(OFS_IRQ_STATUS, 32'h100);
		wr(OFS_CTRL_STATUS, 32'h7);
		p = 0;
		while (pend_cnt < 2 && p < 40) begin @(posedge clk); p++; end
		wr(OFS_CTRL_STATUS, 32'h0);
		chk(32'(pend_cnt >= 2), 32'h1);
		irq_is(1'b1);
		rd(OFS_CTRL_STATUS, 32'h1_0000);
		rd(OFS_CTRL_STATUS, 32'h0);
		wr(OFS_IRQ_STATUS, 32'h0);
		irq_is(1'b0);
		wr(OFS_IRQ_STATUS, 32'h100);
		irq_is(1'b1);
		wr(OFS_IRQ_STATUS, 32'h101);
		irq_is(1'b0);
		wr(OFS_CTRL_STATUS, 32'h7);
		repeat (6) @(posedge clk);
		wr(OFS_CTRL_STATUS, 32'h0);
		wr(OFS_CURRENT, 32'h0);
		rd(OFS_CTRL_STATUS, 32'h0);
	endtask
	task automatic s_zero;
		wr(OFS_RELOAD, 32'h0);
		wr(OFS_CURRENT, 32'h0);
		p = pend_cnt;
		wr(OFS_CTRL_STATUS, 32'h7);
		repeat (8) @(posedge clk);
		rd(OFS_CURRENT, 32'h0);
		chk(pend_cnt, p);
		wr(OFS_CTRL_STATUS, 32'h0);
	endtask
	initial begin
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		s_alt();
		s_core();
		s_zero();
		complete_run();
	end
endmodule // system_tick_down_counter_tb
